// File: verilog/urxes_pkg.sv
// Package: register map, field layout and constants of the receive error status block
package urxes_pkg;
    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [11:0] URXES_OFF_DATA   = 12'h000;
    localparam logic [11:0] URXES_OFF_STATUS = 12'h004;
    localparam logic [11:0] URXES_OFF_FLAGS  = 12'h018;
    localparam logic [11:0] URXES_OFF_LCR    = 12'h02C;
    localparam logic [11:0] URXES_OFF_INTST  = 12'h040;
    localparam logic [11:0] URXES_OFF_INTMSK = 12'h044;
    // ------------------------------------------------------------------
    // Status field positions (also entry bits 11:8 shifted by 8)
    // ------------------------------------------------------------------
    localparam int URXES_FE_BIT = 0;
    localparam int URXES_PE_BIT = 1;
    localparam int URXES_BE_BIT = 2;
    localparam int URXES_OE_BIT = 3;
    // Line flag positions
    localparam int URXES_BUSY_BIT = 3;
    localparam int URXES_RX_EMPTY_FLAG_BIT = 4;
    localparam int URXES_TX_FULL_FLAG_BIT = 5;
    localparam int URXES_RX_FULL_FLAG_BIT = 6;
    localparam int URXES_TX_EMPTY_FLAG_BIT = 7;
    // Line control positions
    localparam int URXES_PEN_BIT = 1;
    localparam int URXES_EPS_BIT = 2;
    localparam int URXES_FEN_BIT = 4;
    localparam int URXES_SPS_BIT = 7;
    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [3:0] URXES_STATUS_RST = 4'h0;
    localparam logic [7:0] URXES_FLAGS_RST  = 8'h90;
    localparam logic [7:0] URXES_LCR_RST    = 8'h00;
    localparam logic [3:0] URXES_MASK_RST   = 4'h0;
    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int URXES_ENTRY_W = 12;
    localparam int URXES_DEPTH   = 16;
endpackage : urxes_pkg

// File: verilog/urxes_top.sv
// Receive error status / error clear block with receive holding FIFO
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
module urxes_top
    import urxes_pkg::*;
#(
    parameter int DEPTH = URXES_DEPTH
) (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    // Register port
    input  wire logic [11:0] i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    // Receive character from the deserialiser (one-cycle strobe)
    input  wire logic        i_char_done,
    input  wire logic [7:0]  i_char_data,
    input  wire logic        i_char_parity,
    input  wire logic        i_char_stop,
    input  wire logic        i_line_break,
    // Transmit side state
    input  wire logic        i_tx_full,
    input  wire logic        i_tx_empty,
    input  wire logic        i_tx_busy,
    // Line control outputs and interrupt
    output logic             o_rx_enable,
    output logic             o_irq
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [3:0]  status;
        logic [7:0]  lcr;
        logic [3:0]  int_st;
        logic [3:0]  int_mask;
        logic [AW:0] count;
        logic [AW-1:0] rd_ptr;
        logic [AW-1:0] wr_ptr;
        logic        brk_hold;
        logic        brk_d1;
        logic [31:0] rdata;
        logic        irq;
    } urxes_state_t;

    urxes_state_t s_q, s_d;
    logic [URXES_ENTRY_W-1:0] mem_q [DEPTH];

    // ------------------------------------------------------------------
    // Line input synchroniser
    // ------------------------------------------------------------------
    logic brk_s1_q, brk_s2_q;
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            brk_s1_q <= 1'b0;
            brk_s2_q <= 1'b0;
        end else begin
            brk_s1_q <= i_line_break;
            brk_s2_q <= brk_s1_q;
        end
    end

    // ------------------------------------------------------------------
    // Derived terms
    // ------------------------------------------------------------------
    logic fifo_en, depth1, full, empty, brk_rise, push, pop, ovr;
    logic exp_par, par_err, frm_err, wr_clr;
    logic rx_ok;
    logic [URXES_ENTRY_W-1:0] entry, top;
    logic [7:0] flags;

    assign fifo_en  = s_q.lcr[URXES_FEN_BIT];
    assign depth1   = fifo_en ? 1'b0 : 1'b1;
    assign full     = depth1 ? (s_q.count != '0) : (s_q.count == (AW+1)'(DEPTH));
    assign empty    = (s_q.count == '0);
    assign brk_rise = brk_s2_q & ~s_q.brk_d1;
    // Stick parity forces the bit to the inverted even-select value
    always_comb begin
        if (s_q.lcr[URXES_SPS_BIT])
            exp_par = ~s_q.lcr[URXES_EPS_BIT];
        else
            exp_par = ^{i_char_data, ~s_q.lcr[URXES_EPS_BIT]};
    end
    assign par_err = s_q.lcr[URXES_PEN_BIT] & (i_char_parity != exp_par);
    assign frm_err = ~i_char_stop;
    // Characters during a break are suppressed until marking and a new start
    // Once the line is marking again, the next character releases the hold
    assign rx_ok   = ~s_q.brk_hold | ~brk_s2_q;
    assign push    = (brk_rise | (i_char_done & rx_ok)) & ~full;
    assign ovr     = (brk_rise | (i_char_done & rx_ok)) & full;
    assign pop     = i_rd & (i_addr == URXES_OFF_DATA) & ~empty;
    assign wr_clr  = i_wr & (i_addr == URXES_OFF_STATUS);
    // Entry: {oe, be, pe, fe, data}; a break stores one zero character
    assign entry   = brk_rise ? {1'b0, 1'b1, 1'b0, 1'b0, 8'h00}
                              : {1'b0, 1'b0, par_err, frm_err, i_char_data};
    assign top     = mem_q[s_q.rd_ptr];
    always_comb begin
        flags = '0;
        flags[URXES_TX_EMPTY_FLAG_BIT] = i_tx_empty;
        flags[URXES_RX_FULL_FLAG_BIT] = full;
        flags[URXES_TX_FULL_FLAG_BIT] = i_tx_full;
        flags[URXES_RX_EMPTY_FLAG_BIT] = empty;
        flags[URXES_BUSY_BIT] = i_tx_busy;
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.brk_d1 = brk_s2_q;
        if (brk_rise)
            s_d.brk_hold = 1'b1;
        else if (!brk_s2_q && i_char_done)
            s_d.brk_hold = 1'b0;
        if (push) begin
            s_d.wr_ptr = depth1 ? s_q.wr_ptr : AW'(s_q.wr_ptr + 1'b1);
        end
        if (pop) begin
            s_d.rd_ptr = depth1 ? s_q.rd_ptr : AW'(s_q.rd_ptr + 1'b1);
        end
        s_d.count = (AW+1)'(s_q.count + (AW+1)'(push) - (AW+1)'(pop));
        // Error clear first so a coincident overrun still sets its bit; a coincident pop's error bits stay cleared
        if (wr_clr)
            s_d.status = '0;
        if (pop) begin
            s_d.status[URXES_BE_BIT:URXES_FE_BIT] = top[10:8];
            if (wr_clr)
                s_d.status[URXES_BE_BIT:URXES_FE_BIT] = '0;
        end
        if (ovr)
            s_d.status[URXES_OE_BIT] = 1'b1;
        // Interrupt status: W1C, set wins over clear
        if (i_wr && i_addr == URXES_OFF_INTST)
            s_d.int_st = s_q.int_st & ~i_wdata[3:0];
        if (ovr)
            s_d.int_st[URXES_OE_BIT] = 1'b1;
        if (push && entry[8 + URXES_BE_BIT])
            s_d.int_st[URXES_BE_BIT] = 1'b1;
        if (push && entry[8 + URXES_PE_BIT])
            s_d.int_st[URXES_PE_BIT] = 1'b1;
        if (push && entry[8 + URXES_FE_BIT])
            s_d.int_st[URXES_FE_BIT] = 1'b1;
        if (i_wr && i_addr == URXES_OFF_INTMSK)
            s_d.int_mask = i_wdata[3:0];
        if (i_wr && i_addr == URXES_OFF_LCR)
            s_d.lcr = i_wdata[7:0];
        s_d.irq = |(s_d.int_st & s_d.int_mask);
        s_d.rdata = '0;
        if (i_rd) begin
            case (i_addr)
                URXES_OFF_DATA:   s_d.rdata = {20'h0, empty ? 12'h000 : top};
                URXES_OFF_STATUS: s_d.rdata = {28'h0, s_q.status};
                URXES_OFF_FLAGS:  s_d.rdata = {24'h0, flags};
                URXES_OFF_LCR:    s_d.rdata = {24'h0, s_q.lcr};
                URXES_OFF_INTST:  s_d.rdata = {28'h0, s_q.int_st};
                URXES_OFF_INTMSK: s_d.rdata = {28'h0, s_q.int_mask};
                default:          s_d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s_q.status   <= URXES_STATUS_RST;
            s_q.lcr      <= URXES_LCR_RST;
            s_q.int_st   <= '0;
            s_q.int_mask <= URXES_MASK_RST;
            s_q.count    <= '0;
            s_q.rd_ptr   <= '0;
            s_q.wr_ptr   <= '0;
            s_q.brk_hold <= 1'b0;
            s_q.brk_d1   <= 1'b0;
            s_q.rdata    <= '0;
            s_q.irq      <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // FIFO storage, written only when not full
    always_ff @(posedge i_clk) begin
        if (push)
            mem_q[s_q.wr_ptr] <= entry;
    end

    assign o_rdata     = s_q.rdata;
    assign o_irq       = s_q.irq;
    assign o_rx_enable = ~s_q.brk_hold;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    sequence s_clear_write;
        i_wr && i_addr == URXES_OFF_STATUS && !ovr && !pop;
    endsequence

    a_clear_all_flags: assert property (s_clear_write |=> s_q.status == 4'h0)
        else $error("error clear write did not zero status");
    a_overrun_sets_now: assert property (ovr |=> s_q.status[URXES_OE_BIT])
        else $error("overrun flag not set next cycle");
    a_overrun_on_full: assert property (i_char_done && rx_ok && full |-> ovr)
        else $error("full fifo char did not flag overrun");
    a_overrun_keeps_fifo: assert property (ovr && !pop |=> s_q.count == $past(s_q.count))
        else $error("fifo count changed on overrun");
    a_overrun_sticky: assert property (s_q.status[URXES_OE_BIT] && !wr_clr |=> s_q.status[URXES_OE_BIT])
        else $error("overrun flag dropped without clear");
    a_status_read_back: assert property (i_rd && i_addr == URXES_OFF_STATUS |=> o_rdata[3:0] == $past(s_q.status))
        else $error("status read mismatch");
    a_pop_latches_errors: assert property (pop && !wr_clr |=> s_q.status[2:0] == $past(top[10:8]))
        else $error("popped entry errors not latched");
    a_break_zero_char: assert property (brk_rise && !full && !pop |=> s_q.brk_hold && s_q.count == $past(s_q.count) + 1'b1)
        else $error("break did not load one character");
    a_break_blocks: assert property (s_q.brk_hold && brk_s2_q && i_char_done |-> !push)
        else $error("character accepted during break");
    a_flags_empty_bit: assert property (i_rd && i_addr == URXES_OFF_FLAGS && empty |=> o_rdata[URXES_RX_EMPTY_FLAG_BIT])
        else $error("rx empty flag wrong");
    a_parity_flag: assert property (push && !brk_rise && s_q.lcr[URXES_PEN_BIT] && i_char_parity != exp_par |-> entry[9])
        else $error("parity error not captured");
    a_framing_flag: assert property (push && !brk_rise && !i_char_stop |-> entry[8])
        else $error("framing error not captured");

    // ------------------------------------------------------------------
    // Named steps
    // ------------------------------------------------------------------
    sequence s_char_taken;
        i_char_done && rx_ok;
    endsequence

    sequence s_char_pushed;
        push && !brk_rise;
    endsequence

    sequence s_data_pop;
        pop;
    endsequence

    sequence s_status_read;
        i_rd && i_addr == URXES_OFF_STATUS;
    endsequence

    sequence s_flags_read;
        i_rd && i_addr == URXES_OFF_FLAGS;
    endsequence

    sequence s_data_read_empty;
        i_rd && i_addr == URXES_OFF_DATA && empty;
    endsequence

    sequence s_break_start;
        brk_rise;
    endsequence

    sequence s_overrun_event;
        ovr;
    endsequence

    sequence s_no_read;
        !i_rd;
    endsequence

    // ------------------------------------------------------------------
    // Receive path checks
    // ------------------------------------------------------------------
    a_clear_drops_overrun: assert property (wr_clr && !ovr |=> !s_q.status[URXES_OE_BIT])
        else $error("error clear left overrun set");
    a_clear_beats_pop: assert property (wr_clr && pop |=> s_q.status[2:0] == 3'h0)
        else $error("error clear lost to coincident pop");
    a_overrun_beats_clear: assert property (wr_clr && ovr |=> s_q.status[URXES_OE_BIT])
        else $error("overrun lost to coincident clear");
    a_char_pushes: assert property (s_char_taken ##0 (!full && !brk_rise && !pop) |=> s_q.count == $past(s_q.count) + 1'b1)
        else $error("accepted character not stored");
    a_overrun_no_push: assert property (s_overrun_event |-> !push)
        else $error("overrun wrote into fifo");
    a_pop_moves_count: assert property (pop && !push |=> s_q.count == $past(s_q.count) - 1'b1)
        else $error("data read did not drain fifo");
    a_overrun_int_set: assert property (s_overrun_event |=> s_q.int_st[URXES_OE_BIT])
        else $error("overrun interrupt not raised");
    a_parity_off_clean: assert property (s_char_pushed ##0 !s_q.lcr[URXES_PEN_BIT] |-> !entry[9])
        else $error("parity error with parity off");
    a_framing_clean: assert property (s_char_pushed ##0 i_char_stop |-> !entry[8])
        else $error("framing error with good stop");
    a_entry_keeps_data: assert property (s_char_pushed |-> entry[7:0] == i_char_data)
        else $error("stored byte differs");
    a_entry_no_overrun: assert property (push |-> !entry[11])
        else $error("overrun bit stored in entry");
    a_fifo_top_errors: assert property (s_data_pop |=> s_q.status[URXES_BE_BIT] == ($past(top[10]) && !$past(wr_clr)))
        else $error("top entry break not latched");

    // ------------------------------------------------------------------
    // Register read checks
    // ------------------------------------------------------------------
    a_empty_read_zero: assert property (s_data_read_empty |=> o_rdata == 32'h0)
        else $error("empty data read not zero");
    a_empty_no_pop: assert property (s_data_read_empty |-> !pop)
        else $error("pop from empty fifo");
    a_rdata_idle_zero: assert property (s_no_read |=> o_rdata == 32'h0)
        else $error("read data not zero when idle");
    a_status_upper_zero: assert property (s_status_read |=> o_rdata[31:4] == 28'h0)
        else $error("status upper bits not zero");
    a_status_oe_read: assert property (s_status_read ##0 s_q.status[URXES_OE_BIT] |=> o_rdata[URXES_OE_BIT])
        else $error("overrun not visible in status read");
    a_flags_full_bit: assert property (s_flags_read ##0 full |=> o_rdata[URXES_RX_FULL_FLAG_BIT])
        else $error("rx full flag wrong");
    a_flags_tx_empty: assert property (s_flags_read |=> o_rdata[URXES_TX_EMPTY_FLAG_BIT] == $past(i_tx_empty))
        else $error("tx empty flag wrong");
    a_flags_tx_full: assert property (s_flags_read |=> o_rdata[URXES_TX_FULL_FLAG_BIT] == $past(i_tx_full))
        else $error("tx full flag wrong");
    a_flags_busy_bit: assert property (s_flags_read |=> o_rdata[URXES_BUSY_BIT] == $past(i_tx_busy))
        else $error("busy flag wrong");
    a_flags_low_zero: assert property (s_flags_read |=> o_rdata[2:0] == 3'h0)
        else $error("flag low bits not zero");

    // ------------------------------------------------------------------
    // Break checks
    // ------------------------------------------------------------------
    a_break_entry_zero: assert property (s_break_start |-> entry == 12'h400)
        else $error("break entry not a zero character");
    a_break_sets_hold: assert property (s_break_start |=> s_q.brk_hold)
        else $error("break did not hold receiver");
    a_hold_rx_disable: assert property (s_q.brk_hold |-> !o_rx_enable)
        else $error("receiver enabled during hold");
    a_hold_release: assert property (s_q.brk_hold && !brk_s2_q && i_char_done |=> !s_q.brk_hold)
        else $error("hold not released after marking");
    a_after_break_accept: assert property (s_q.brk_hold && !brk_s2_q && i_char_done && !full |-> push)
        else $error("first character after break dropped");
endmodule : urxes_top

// File: testbench/urxes_char_src.sv
// Far-side character source feeding the receive error block
`timescale 1ns/1ps
module urxes_char_src (
    // Clock
    input  wire logic       i_clk,
    // Character link
    output logic            o_char_done,
    output logic      [7:0] o_char_data,
    output logic            o_char_parity,
    output logic            o_char_stop,
    output logic            o_line_break
);
    initial begin
        o_char_done   = 1'h0;
        o_char_data   = 8'h00;
        o_char_parity = 1'h0;
        o_char_stop   = 1'h1;
        o_line_break  = 1'h0;
    end
    task automatic send_char(input logic [7:0] d, input logic p, input logic s);
        @(posedge i_clk);
        o_char_done   <= 1'h1;
        o_char_data   <= d;
        o_char_parity <= p;
        o_char_stop   <= s;
        @(posedge i_clk);
        // Fields are void after the strobe: show their inverse
        o_char_done   <= 1'h0;
        o_char_data   <= ~d;
        o_char_parity <= ~p;
        o_char_stop   <= ~s;
    endtask : send_char
    task automatic set_break(input logic b);
        @(posedge i_clk);
        o_line_break <= b;
    endtask : set_break
endmodule : urxes_char_src

// File: testbench/tb_top.sv
// Self-checking testbench of the receive error status block
`timescale 1ns/1ps
module tb_top;
    import urxes_pkg::*;
    logic        i_clk, i_reset_n, i_wr, i_rd, i_tx_full, i_tx_empty, i_tx_busy;
    logic [11:0] i_addr;
    logic [31:0] i_wdata, o_rdata;
    logic        o_rx_enable, o_irq, c_done, c_par, c_stop, c_brk;
    logic [7:0]  c_data;
    int          fail_count = 0;
    int          checks = 0;

    urxes_top #(.DEPTH(4)) i_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_char_done(c_done), .i_char_data(c_data), .i_char_parity(c_par),
        .i_char_stop(c_stop), .i_line_break(c_brk), .i_tx_full(i_tx_full),
        .i_tx_empty(i_tx_empty), .i_tx_busy(i_tx_busy), .o_rx_enable(o_rx_enable),
        .o_irq(o_irq));
    urxes_char_src i_src (.i_clk(i_clk), .o_char_done(c_done), .o_char_data(c_data),
        .o_char_parity(c_par), .o_char_stop(c_stop), .o_line_break(c_brk));

    task automatic finish_test();
        if (fail_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr    <= 1'h1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr    <= 1'h0;
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge i_clk);
        i_rd   <= 1'h1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd   <= 1'h0;
        #1;
        d = o_rdata;
    endtask : rd
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        chk(d, e);
    endtask : rchk
    task automatic wait_rx();
        logic [31:0] d;
        for (int n = 0; n < 50; n++) begin
            rd(URXES_OFF_FLAGS, d);
            if (d[URXES_RX_EMPTY_FLAG_BIT] === 1'h0) return;
        end
        fail_count++;
        finish_test();
    endtask : wait_rx
    task automatic wait_irq(input logic e);
        for (int n = 0; n < 8 && o_irq !== e; n++) begin
            @(posedge i_clk);
            #1;
        end
        chk({31'h0, o_irq}, {31'h0, e});
    endtask : wait_irq

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        rchk(URXES_OFF_STATUS, 32'h0);
        rchk(URXES_OFF_FLAGS, 32'h90);
        rchk(12'h100, 32'h0);
        chk({31'h0, o_rx_enable}, 32'h1);
        i_tx_full  <= 1'h1;
        i_tx_empty <= 1'h0;
        i_tx_busy  <= 1'h1;
        rchk(URXES_OFF_FLAGS, 32'h38);
        i_tx_full  <= 1'h0;
        i_tx_empty <= 1'h1;
        i_tx_busy  <= 1'h0;
    endtask : t_reset
    task automatic t_errors();
        wr(URXES_OFF_LCR, 32'h16);
        i_src.send_char(8'h05, 1'h0, 1'h1);
        i_src.send_char(8'h03, 1'h1, 1'h1);
        i_src.send_char(8'hA5, 1'h0, 1'h0);
        rchk(URXES_OFF_DATA, 32'h005);
        rchk(URXES_OFF_STATUS, 32'h0);
        rchk(URXES_OFF_DATA, 32'h203);
        rchk(URXES_OFF_STATUS, 32'h2);
        rchk(URXES_OFF_DATA, 32'h1A5);
        rchk(URXES_OFF_STATUS, 32'h1);
    endtask : t_errors
    task automatic t_overrun();
        logic [31:0] d;
        for (int i = 0; i < 4; i++) i_src.send_char(8'h10 + 8'(i), ^(8'h10 + 8'(i)), 1'h1);
        rchk(URXES_OFF_FLAGS, 32'hC0);
        i_src.send_char(8'h55, 1'h0, 1'h1);
        rchk(URXES_OFF_STATUS, 32'h9);
        for (int i = 0; i < 4; i++) begin
            rd(URXES_OFF_DATA, d);
            chk(d & 32'h7FF, 32'h10 + 32'(i));
        end
        rchk(URXES_OFF_FLAGS, 32'h90);
        rchk(URXES_OFF_STATUS, 32'h8);
        wr(URXES_OFF_STATUS, 32'hFFFFFFFF);
        rchk(URXES_OFF_STATUS, 32'h0);
    endtask : t_overrun
    task automatic t_break();
        i_src.set_break(1'h1);
        wait_rx();
        rchk(URXES_OFF_DATA, 32'h400);
        rchk(URXES_OFF_STATUS, 32'h4);
        i_src.send_char(8'h77, 1'h1, 1'h1);
        rchk(URXES_OFF_FLAGS, 32'h90);
        chk({31'h0, o_rx_enable}, 32'h0);
        i_src.set_break(1'h0);
        repeat (4) @(posedge i_clk);
        i_src.send_char(8'h21, 1'h0, 1'h1);
        rchk(URXES_OFF_DATA, 32'h021);
        rchk(URXES_OFF_STATUS, 32'h0);
        chk({31'h0, o_rx_enable}, 32'h1);
        wr(URXES_OFF_STATUS, 32'h0);
    endtask : t_break
    task automatic t_irq();
        wr(URXES_OFF_INTST, 32'hF);
        wr(URXES_OFF_INTMSK, 32'h0);
        i_src.send_char(8'h03, 1'h1, 1'h1);
        wait_irq(1'h0);
        wr(URXES_OFF_INTMSK, 32'h2);
        wait_irq(1'h1);
        wr(URXES_OFF_INTST, 32'h2);
        wait_irq(1'h0);
        rchk(URXES_OFF_DATA, 32'h203);
    endtask : t_irq

    initial begin
        i_clk = 1'h0;
        forever #25 i_clk = ~i_clk;
    end
    initial begin
        i_reset_n  = 1'h0;
        i_wr       = 1'h0;
        i_rd       = 1'h0;
        i_addr     = 12'h000;
        i_wdata    = 32'h0;
        i_tx_full  = 1'h0;
        i_tx_empty = 1'h1;
        i_tx_busy  = 1'h0;
        repeat (16) @(posedge i_clk);
        i_reset_n <= 1'h1;
        t_reset();
        t_errors();
        t_overrun();
        t_break();
        t_irq();
        finish_test();
    end
endmodule : tb_top
